/* pkg/sos_consts.vh */
// timing and width constants for the start-up and overcurrent sequencer
`ifndef SOS_CONSTS_VH
`define SOS_CONSTS_VH
`define SOS_CLK_MHZ 250
`define SOS_DELAY_US 6800
`define SOS_DELAY_CYC (`SOS_DELAY_US * `SOS_CLK_MHZ)
`define SOS_RAMP_US 6800
`define SOS_RAMP_STEPS 64
`define SOS_STEP_CYC ((`SOS_RAMP_US * `SOS_CLK_MHZ) / `SOS_RAMP_STEPS)
`define SOS_SAMPLE_MAX_US 3400
`define SOS_SAMPLE_CYC (`SOS_SAMPLE_MAX_US * `SOS_CLK_MHZ)
`define SOS_INIT_CYC 16
`define SOS_BLANK_NS 200
`define SOS_BLANK_CYC ((`SOS_BLANK_NS * `SOS_CLK_MHZ) / 1000)
`define SOS_MINLS_NS 425
`define SOS_MINLS_CYC ((`SOS_MINLS_NS * `SOS_CLK_MHZ + 999) / 1000)
`define SOS_NARROW_LIMIT 3
`define SOS_DUMMY_CYCLES 2
`define SOS_SET_W 8
`endif

/* hdl/sos_sequencer.v */
// start-up, soft-start and overcurrent hiccup sequencer
// Contract
// - reference ramps zero to final over ramp time
// - ramp is 64 fixed equal digital steps
// - error amp enabled after short init interval
// - ramp passing final level ends soft-start
// - total start-up bounded by delay plus ramp; the code adds sample and init time on top
// - prebias low: switches off until ramp exceeds
// - prebias high: switches off whole ramp, then pull
// - soft-start completes even without input rail
// - enable release repeats full initialization
// - no new set-point sample during retry
// - overcurrent protection active during soft-start
// - overcurrent turns output off at once
// - hiccup: two dummy timeouts then one try
// - sample starts after reset plus delay
// - sampling disables low gate, drives source
// - set point held in counter for DAC
// - monitoring starts after blanking delay
// - monitoring stops when low gate falls
// - third narrow low pulse stretched to minimum
// - trip at twice the held set point
// - start when bias rail passes reset threshold
// - defer start while enable held low
// - retry period between two and three ramps
// - timing from own clock, not switching clock
`timescale 1ns/10ps
`include "sos_consts.vh"
module sos_sequencer #(
  parameter integer DELAY_CYC = `SOS_DELAY_CYC,
  parameter integer STEP_CYC = `SOS_STEP_CYC,
  parameter integer SAMPLE_CYC = `SOS_SAMPLE_CYC,
  parameter integer SET_W = `SOS_SET_W
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // supply and enable monitors
  input wire i_bias_supply_ok,
  input wire i_enable_above_trip,
  // set-point sampling: comparator of dac against pin voltage
  input wire i_sample_reached,
  // output prebias comparators (output vs ramp, output vs target)
  input wire i_out_above_ramp,
  input wire i_out_above_target,
  // switching pwm and low-side current sense
  input wire i_pwm_low_gate,
  input wire i_low_drop_over_trip,
  // control outputs
  output reg o_ref_ramp_en,
  output reg [5:0] o_ref_step,
  output reg o_err_amp_en,
  output reg o_switch_en,
  output reg o_soft_start_done,
  output reg o_sample_current_source,
  output reg o_low_gate_disable,
  output reg [SET_W-1:0] o_trip_dac,
  output reg [SET_W:0] o_trip_compare,
  output reg o_low_gate,
  output reg o_overcurrent_guard
);
  // overview of the sequence, as seen from the output pins:
  // - wait: nothing switches; the low gate driver is held disabled
  // - delay: fixed settling time so the bias regulator starts cleanly
  // - sample: the trip dac counts up until it meets the pin voltage
  // - init: short pause before the error amplifier is let loose
  // - ramp: reference climbs in equal steps from zero
  // - regulate: reference sits at its final level
  // - hiccup: two dummy ramp times, then one real ramp attempt
  // limitations a user must know:
  // - the ramp rate is fixed by STEP_CYC; nothing outside can change it
  // - a missing low pulse is not inserted, only a narrow one stretched
  // - the held set point survives shut-down until the next sample,
  //   but is forgotten when the bias rail drops
  // - every interval is counted on i_clk alone, so the switching
  //   frequency never changes start-up or retry timing
  // trade-off: a single 32-bit interval timer is shared by all timed states
  // instead of one counter per interval; it costs a wide comparator
  // per state but keeps the flop count low
  // hazard: the trip term is combinational from a pin input, so every
  // output that must drop at once on a trip is gated by it directly
  // rather than waiting for the state register to move on

  // one-hot states
  localparam [6:0] ST_WAIT = 7'h01;
  localparam [6:0] ST_DELAY = 7'h02;
  localparam [6:0] ST_SAMPLE = 7'h04;
  localparam [6:0] ST_INIT = 7'h08;
  localparam [6:0] ST_RAMP = 7'h10;
  localparam [6:0] ST_REG = 7'h20;
  localparam [6:0] ST_HICCUP = 7'h40;
  localparam [31:0] BLANK = `SOS_BLANK_CYC;
  localparam [31:0] MINLS = `SOS_MINLS_CYC;

  reg [6:0] state_q; // sequencer state
  reg [31:0] timer_q; // shared interval timer
  reg [6:0] step_q; // ramp step count, bit 6 = past final
  reg [1:0] dummy_q; // dummy timeouts done in hiccup
  reg have_set_q; // a set point was sampled
  reg prebias_lo_q; // output below target but above ramp
  reg prebias_hi_q; // output above target at start
  reg [7:0] blank_q; // low-side window timer
  reg [1:0] narrow_q; // consecutive narrow pulses
  reg stretch_q; // stretching a narrow pulse to minimum
  reg [7:0] stretch_cnt_q; // stretched pulse width count
  reg pwm_d1_q; // previous pwm level for edges
  wire trip; // qualified overcurrent event

  // window: blanking after pwm rise, ends when the low gate falls
  wire pwm_rise = i_pwm_low_gate & ~pwm_d1_q;
  wire pwm_fall = ~i_pwm_low_gate & pwm_d1_q;
  wire gate_now = i_pwm_low_gate | stretch_q;
  wire window = gate_now & (blank_q >= BLANK[7:0]);
  // outside ramp/regulate nothing switches, so no trips count
  assign trip = window & i_low_drop_over_trip & o_switch_en &
    (state_q == ST_RAMP || state_q == ST_REG);

  // low-side window and narrow-pulse stretching
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      pwm_d1_q <= 1'b0;
      blank_q <= 8'h00;
      narrow_q <= 2'h0;
      stretch_q <= 1'b0;
      stretch_cnt_q <= 8'h00;
    end else begin
      pwm_d1_q <= i_pwm_low_gate;
      // blanking count restarts on each pwm rising edge
      if (pwm_rise)
        blank_q <= 8'h01;
      else if (gate_now && blank_q != 8'hff)
        blank_q <= blank_q + 8'h01;
      else if (!gate_now)
        blank_q <= 8'h00;
      // a low pulse shorter than minimum counts as narrow
      if (pwm_fall && !stretch_q) begin
        if (blank_q < MINLS[7:0]) begin
          if (narrow_q == `SOS_NARROW_LIMIT - 1) begin
            // third narrow pulse: stretch it to minimum width
            stretch_q <= 1'b1;
            stretch_cnt_q <= blank_q;
            narrow_q <= 2'h0;
          end else begin
            narrow_q <= narrow_q + 2'h1;
          end
        end else begin
          narrow_q <= 2'h0;
        end
      end
      if (stretch_q) begin
        stretch_cnt_q <= stretch_cnt_q + 8'h01;
        if (stretch_cnt_q >= MINLS[7:0] - 8'h01)
          stretch_q <= 1'b0;
      end
    end
  end

  // main sequencer
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q <= ST_WAIT;
      timer_q <= 32'h0000_0000;
      step_q <= 7'h00;
      dummy_q <= 2'h0;
      have_set_q <= 1'b0;
      prebias_lo_q <= 1'b0;
      prebias_hi_q <= 1'b0;
      o_trip_dac <= {SET_W{1'b0}};
    end else if (!i_bias_supply_ok) begin
      // bias lost: held set point is gone too
      state_q <= ST_WAIT;
      have_set_q <= 1'b0;
      step_q <= 7'h00;
      timer_q <= 32'h0000_0000;
    end else if (!i_enable_above_trip) begin
      // shut-down: hold off and re-sample after release
      state_q <= ST_WAIT;
      step_q <= 7'h00;
      timer_q <= 32'h0000_0000;
    end else begin
      case (state_q)
        ST_WAIT: begin
          state_q <= ST_DELAY;
          timer_q <= 32'h0000_0000;
        end
        ST_DELAY: begin
          // fixed post-reset delay, own clock only
          timer_q <= timer_q + 32'h0000_0001;
          if (timer_q >= DELAY_CYC - 1) begin
            state_q <= ST_SAMPLE;
            timer_q <= 32'h0000_0000;
            o_trip_dac <= {SET_W{1'b0}};
          end
        end
        ST_SAMPLE: begin
          // counter climbs until dac meets pin voltage
          timer_q <= timer_q + 32'h0000_0001;
          if (i_sample_reached || &o_trip_dac ||
              timer_q >= SAMPLE_CYC - 1) begin
            state_q <= ST_INIT;
            have_set_q <= 1'b1;
            timer_q <= 32'h0000_0000;
            prebias_hi_q <= i_out_above_target;
          end else begin
            o_trip_dac <= o_trip_dac + {{(SET_W-1){1'b0}}, 1'b1};
          end
        end
        ST_INIT: begin
          timer_q <= timer_q + 32'h0000_0001;
          if (timer_q >= `SOS_INIT_CYC - 1) begin
            state_q <= ST_RAMP;
            timer_q <= 32'h0000_0000;
            step_q <= 7'h00;
            prebias_lo_q <= i_out_above_ramp & ~prebias_hi_q;
          end
        end
        ST_RAMP: begin
          if (trip) begin
            state_q <= ST_HICCUP;
            dummy_q <= 2'h0;
            step_q <= 7'h00;
            timer_q <= 32'h0000_0000;
          end else begin
            timer_q <= timer_q + 32'h0000_0001;
            // ramp advances regardless of output
            if (timer_q >= STEP_CYC - 1) begin
              timer_q <= 32'h0000_0000;
              step_q <= step_q + 7'h01;
            end
            if (prebias_lo_q && !i_out_above_ramp)
              prebias_lo_q <= 1'b0;
            if (step_q[6]) begin
              state_q <= ST_REG;
              prebias_hi_q <= 1'b0;
              prebias_lo_q <= 1'b0;
            end
          end
        end
        ST_REG: begin
          if (trip) begin
            state_q <= ST_HICCUP;
            dummy_q <= 2'h0;
            step_q <= 7'h00;
            timer_q <= 32'h0000_0000;
          end
        end
        ST_HICCUP: begin
          // dummy ramp timeouts; held set point reused
          timer_q <= timer_q + 32'h0000_0001;
          if (timer_q >= STEP_CYC * `SOS_RAMP_STEPS - 1) begin
            timer_q <= 32'h0000_0000;
            if (dummy_q == `SOS_DUMMY_CYCLES - 1) begin
              state_q <= ST_RAMP;
              step_q <= 7'h00;
              prebias_hi_q <= 1'b0;
              prebias_lo_q <= i_out_above_ramp;
            end else begin
              dummy_q <= dummy_q + 2'h1;
            end
          end
        end
        default: begin
          state_q <= ST_WAIT;
        end
      endcase
    end
  end

  // registered outputs
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_ref_ramp_en <= 1'b0;
      o_ref_step <= 6'h00;
      o_err_amp_en <= 1'b0;
      o_switch_en <= 1'b0;
      o_soft_start_done <= 1'b0;
      o_sample_current_source <= 1'b0;
      o_low_gate_disable <= 1'b1;
      o_trip_compare <= {(SET_W+1){1'b0}};
      o_low_gate <= 1'b0;
      o_overcurrent_guard <= 1'b0;
    end else begin
      // ramp, amplifier and done drop in the same cycle as the trip
      o_ref_ramp_en <= ~trip & (state_q == ST_RAMP);
      // final level is all ones once the ramp has passed it
      o_ref_step <= step_q[6] || state_q == ST_REG ? 6'h3f :
        step_q[5:0];
      o_err_amp_en <= ~trip &
        (state_q == ST_RAMP || state_q == ST_REG);
      // off at once on trip; off during prebias holds
      o_switch_en <= ~trip & ((state_q == ST_RAMP && !prebias_lo_q &&
        !prebias_hi_q) || state_q == ST_REG);
      o_soft_start_done <= ~trip & (state_q == ST_REG);
      o_sample_current_source <= (state_q == ST_DELAY ||
        state_q == ST_SAMPLE);
      o_low_gate_disable <= ~(state_q == ST_RAMP || state_q == ST_REG);
      // comparison threshold is double the held setting
      o_trip_compare <= have_set_q ? {o_trip_dac, 1'b0} :
        {(SET_W+1){1'b0}};
      o_low_gate <= gate_now & o_switch_en & ~trip;
      o_overcurrent_guard <= trip;
    end
  end
endmodule // sos_sequencer

/* test/sos_seq_checker_assertions.sv */
// port-level assertions for the start-up and overcurrent sequencer
`timescale 1ns/10ps
module sos_seq_checker #(
  parameter integer SET_W = 8
) (
  // clock and reset
  input wire i_clk,
  input wire i_rst_n,
  // watched outputs
  input wire o_ref_ramp_en,
  input wire [5:0] o_ref_step,
  input wire o_err_amp_en,
  input wire o_switch_en,
  input wire o_soft_start_done,
  input wire o_sample_current_source,
  input wire o_low_gate_disable,
  input wire [SET_W-1:0] o_trip_dac,
  input wire [SET_W:0] o_trip_compare,
  input wire o_low_gate,
  input wire o_overcurrent_guard
);
  // one clock domain, so one default clock and reset
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  property p_off; o_overcurrent_guard |-> !o_switch_en && !o_err_amp_en;
  endproperty
  a_off: assert property (p_off) else $error("switch on at trip");
  // a trip is one pulse and no ramp restarts straight away
  property p_quiet;
    o_overcurrent_guard |=> (!o_overcurrent_guard && !o_ref_ramp_en) [*8];
  endproperty
  a_quiet: assert property (p_quiet) else $error("no hiccup");
  property p_hold; o_overcurrent_guard |=> $stable(o_trip_dac) [*8];
  endproperty
  a_hold: assert property (p_hold) else $error("resampled");
  property p_dbl; $stable(o_trip_dac) [*2] |-> o_trip_compare == {o_trip_dac, 1'b0};
  endproperty
  a_dbl: assert property (p_dbl) else $error("bad trip level");
  property p_smp;
    o_sample_current_source |-> o_low_gate_disable && !o_low_gate && !o_switch_en;
  endproperty
  a_smp: assert property (p_smp) else $error("gate on in sample");
  property p_amp; o_ref_ramp_en |-> o_err_amp_en && !o_low_gate_disable;
  endproperty
  a_amp: assert property (p_amp) else $error("amp off in ramp");
  // each step is one count up and then stands for the next three cycles
  property p_stp;
    o_ref_ramp_en && $past(o_ref_ramp_en) && $changed(o_ref_step) |->
      o_ref_step == $past(o_ref_step) + 6'h01 ##1
      (!o_ref_ramp_en || $stable(o_ref_step)) [*3];
  endproperty
  a_stp: assert property (p_stp) else $error("uneven step");
  property p_dn; $rose(o_soft_start_done) |-> o_ref_step == 6'h3f && o_err_amp_en;
  endproperty
  a_dn: assert property (p_dn) else $error("early done");
  c_trip: cover property (o_overcurrent_guard);
  c_done: cover property ($rose(o_soft_start_done));
  c_wide: cover property (o_low_gate [*8]);
endmodule // sos_seq_checker
bind sos_sequencer sos_seq_checker #(.SET_W(SET_W)) u_chk (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .o_ref_ramp_en(o_ref_ramp_en),
  .o_ref_step(o_ref_step), .o_err_amp_en(o_err_amp_en),
  .o_switch_en(o_switch_en), .o_soft_start_done(o_soft_start_done),
  .o_sample_current_source(o_sample_current_source),
  .o_low_gate_disable(o_low_gate_disable), .o_trip_dac(o_trip_dac),
  .o_trip_compare(o_trip_compare), .o_low_gate(o_low_gate),
  .o_overcurrent_guard(o_overcurrent_guard));

/* test/sos_load_model.sv */
// far side: enable pull-down, trip resistor, output and load
`timescale 1ns/10ps
module sos_load_model (
  // bench controls
  input wire i_hold_low,
  input wire [7:0] i_setting,
  input wire [5:0] i_prebias_step,
  input wire i_prebias_high,
  input wire i_short,
  // sequencer outputs
  input wire [7:0] i_trip_dac,
  input wire [5:0] i_ref_step,
  input wire i_low_gate,
  // comparator levels back
  output wire o_enable_above_trip,
  output wire o_sample_reached,
  output wire o_out_above_ramp,
  output wire o_out_above_target,
  output wire o_low_drop_over_trip
);
  assign o_enable_above_trip = !i_hold_low;
  assign o_sample_reached = i_trip_dac >= i_setting;
  assign o_out_above_ramp = i_prebias_high || i_ref_step < i_prebias_step;
  assign o_out_above_target = i_prebias_high;
  // a short shows a big drop only while the low switch conducts
  assign o_low_drop_over_trip = i_short && i_low_gate;
endmodule // sos_load_model

/* test/sos_sequencer_tb_top.sv */
// self-checking bench for the start-up and overcurrent sequencer
`timescale 1ns/10ps
module sos_sequencer_tb_top;
  localparam integer RAMP = 64 * 4;
  logic clk = 1'b0;
  logic rst_n, bias_ok, hold_low, pb_high, short_on, pwm;
  logic [7:0] setting;
  logic [5:0] pb_step;
  wire ramp_en, err_en, sw_en, done, src_on, lg_dis, low_gate, guard;
  wire en_ok, reached, above_ramp, above_tgt, drop_trip;
  wire [5:0] step;
  wire [7:0] trip_dac;
  wire [8:0] trip_cmp;
  int errors = 0;
  int checks = 0;
  int g, hi;
  // short counts keep the run brief
  sos_sequencer #(.DELAY_CYC(20), .STEP_CYC(4), .SAMPLE_CYC(300)) DUT (
    .i_clk(clk), .i_rst_n(rst_n), .i_bias_supply_ok(bias_ok),
    .i_enable_above_trip(en_ok), .i_sample_reached(reached),
    .i_out_above_ramp(above_ramp), .i_out_above_target(above_tgt),
    .i_pwm_low_gate(pwm), .i_low_drop_over_trip(drop_trip),
    .o_ref_ramp_en(ramp_en), .o_ref_step(step), .o_err_amp_en(err_en),
    .o_switch_en(sw_en), .o_soft_start_done(done),
    .o_sample_current_source(src_on), .o_low_gate_disable(lg_dis),
    .o_trip_dac(trip_dac), .o_trip_compare(trip_cmp),
    .o_low_gate(low_gate), .o_overcurrent_guard(guard));
  sos_load_model u_load (
    .i_hold_low(hold_low), .i_setting(setting), .i_prebias_step(pb_step),
    .i_prebias_high(pb_high), .i_short(short_on), .i_trip_dac(trip_dac),
    .i_ref_step(step), .i_low_gate(low_gate), .o_enable_above_trip(en_ok),
    .o_sample_reached(reached), .o_out_above_ramp(above_ramp),
    .o_out_above_target(above_tgt), .o_low_drop_over_trip(drop_trip));
  always #2 clk = ~clk;
  task automatic stop_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // bounded wait for ramp start or soft-start end
  task automatic wt(input bit ramp, input int bound);
    for (int n = 0; (ramp ? ramp_en : done) !== 1'b1; n++) begin
      if (n > bound) begin
        errors++;
        stop_test();
      end
      @(negedge clk);
    end
  endtask
  // one low-gate request, then a quiet tail where stretching shows
  task automatic pulse(input int w);
    g = 0;
    hi = 0;
    for (int i = 0; i < w + 150; i++) begin
      @(posedge clk);
      pwm <= (i < w);
      @(negedge clk);
      g += guard;
      hi += low_gate;
    end
  endtask
  task automatic t_start;
    rst_n <= 1'b1;
    repeat (30) @(posedge clk);
    chk(src_on, 1'b0);
    bias_ok <= 1'b1;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(lg_dis, 1'b1);
    chk(src_on, 1'b1);
    wt(1'b0, 20 + 300 + 16 + RAMP + 20);
    chk(trip_dac, setting);
    chk(trip_cmp, {setting, 1'b0});
    chk(step, 6'h3f);
    chk({sw_en, err_en}, 2'h3);
    pulse(20);
    pulse(20);
    chk(hi, 20);
    pulse(20);
    chk(hi >= 106, 1'b1);
    $display("test start ended");
  endtask
  task automatic t_trip;
    short_on <= 1'b1;
    pulse(40);
    chk(g, 0);
    pulse(150);
    chk({g[3:0], sw_en}, 5'h02);
    g = 0;
    repeat (200) @(negedge clk) g += ramp_en;
    chk(g, 0);
    short_on <= 1'b0;
    wt(1'b0, 3 * RAMP + 40);
    chk(trip_dac, setting);
    $display("test trip ended");
  endtask
  // shut down, restart with new set point and output bias
  task automatic t_restart(input bit high, input int ps, input int set);
    @(posedge clk);
    {hold_low, pb_high, pb_step, setting} <= {1'b1, high, 6'(ps), 8'(set)};
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk(sw_en, 1'b0);
    hold_low <= 1'b0;
    wt(1'b1, 400);
    chk(trip_dac, set);
    g = 0;
    repeat (RAMP) @(negedge clk) g += sw_en && ramp_en && (high || step + 2 < ps);
    chk(g, 0);
    wt(1'b0, 40);
    chk(sw_en, 1'b1);
    $display("test restart ended");
  endtask
  initial begin
    {rst_n, bias_ok, hold_low, pb_high, short_on, pwm} = 6'h00;
    setting = 8'h05;
    pb_step = 6'h00;
    repeat (20) @(posedge clk);
    t_start;
    t_trip;
    t_restart(1'b0, 0, 'h21);
    t_restart(1'b1, 0, 'h09);
    t_restart(1'b0, 20, 'h09);
    stop_test;
  end
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    stop_test;
  end
endmodule // sos_sequencer_tb_top
